// ===== core/exec_subset_defines.vh
/*
  Constants for the instruction execute subset: register byte addresses,
  status bit positions, opcode field layout, opcode codes and reset values.
  Assumes it is included by its bare name from the core design file.
*/
`ifndef EXEC_SUBSET_DEFINES_VH
`define EXEC_SUBSET_DEFINES_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_COMMAND       8'h00
`define ADDR_ACC           8'h04
`define ADDR_OPTION        8'h08
`define ADDR_STATUS        8'h0C
`define ADDR_PC            8'h10
`define ADDR_RETURN_TOP    8'h14
`define ADDR_CORE_STATE    8'h18
`define ADDR_FILE_BASE     8'h80

// ****************************************************************
// Status register bit positions and reset value
// ****************************************************************
`define ST_CARRY           0
`define ST_DIGIT_CARRY     1
`define ST_ZERO            2
`define ST_POWERDOWN_N     3
`define ST_TIMEOUT_N       4
`define ST_PIN_WAKE        7
`define STATUS_RESET       8'h18

// ****************************************************************
// Core state register bit positions
// ****************************************************************
`define CS_DISCARD         0
`define CS_SLEEPING        1

// ****************************************************************
// Instruction word layout
// ****************************************************************
`define OP_MSB             11
`define OP_LSB             8
`define LIT_MSB            7
`define FADDR_MSB          4
`define DEST_BIT           5

// ****************************************************************
// Opcode codes
// ****************************************************************
`define OP_IDLE            4'h0
`define OP_OPTION_LOAD     4'h1
`define OP_SLEEP           4'h2
`define OP_LOAD_LITERAL    4'h3
`define OP_RETURN_LITERAL  4'h4
`define OP_ROTATE_LEFT     4'h5
`define OP_ROTATE_RIGHT    4'h6
`define OP_SUBTRACT        4'h7

// ****************************************************************
// Reset values and watchdog count step
// ****************************************************************
`define ACC_RESET          8'h00
`define OPTION_RESET       8'hFF
`define PC_RESET           9'h000
`define WDT_CLEARED        8'h00
`define WDT_STEP           8'h01

`endif

// ===== core/exec_subset_core.v
/*
  Execute unit for a small subset of an 8-bit core's instructions, with
  its accumulator, option register, status flags, file registers, program
  counter and return stack top reachable over an AHB-Lite slave port.
  Assumes a single AHB-Lite master, hready wired back from hreadyout,
  word transfers only, and a wake request that arrives asynchronously.
  Instructions arrive as writes to the command word; there is no fetch unit.
  The watchdog prescaler lives outside and clears on the watchdog_clear_o pulse.
  Only the top of the return stack is held here; deeper levels live elsewhere.

  // Function
  // - Literal load puts the 8-bit immediate in the accumulator, flags untouched.
  // - Option load copies the accumulator to the option register, flags untouched.
  // - Return with literal loads accumulator and takes program counter from stack top.
  // - Return with literal lasts two cycles, discarding the prefetched next instruction.
  // - Sleep entry clears the watchdog counter to zero and its prescaler.
  // - Sleep entry sets timeout flag, clears powerdown flag, keeps pin wake flag.
  // - After sleep entry the core halts, oscillator stopped, until wake or reset.
  // - Rotate left shifts addressed file register left through carry, only carry changes.
  // - Rotate right shifts addressed file register right through carry, only carry changes.
  // - Destination bit zero writes the accumulator, one writes the file register.
  // - Subtract computes file minus accumulator, updating carry, digit carry and zero.
*/
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "exec_subset_defines.vh"

module exec_subset_core #(
  parameter FILE_WORDS = 32
) (
  // Clock, reset and clock enable
  input  wire        ref_clk_i,
  input  wire        reset_n_i,
  input  wire        clk_en_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [7:0]  haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // Wake request from the pin, asynchronous
  input  wire        wake_i,
  // Links to the rest of the core
  output reg  [7:0]  acc_o,
  output reg  [7:0]  option_o,
  output reg  [7:0]  watchdog_counter_o,
  output reg         watchdog_clear_o,
  output reg         osc_stop_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // One function serves both directions so the bit order lives in one place
  // Rotate through carry; returns {new_carry, result}
  function [8:0] rotate_carry;
    input [7:0] value;
    input       carry_in;
    input       to_left;
    begin
      if (to_left) begin
        rotate_carry = {value[7], value[6:0], carry_in};
      end else begin
        rotate_carry = {value[0], carry_in, value[7:1]};
      end
    end
  endfunction

  // Word address inside the file register window
  function [4:0] file_index;
    input [7:0] addr;
    begin
      file_index = addr[6:2];
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  // Core state, bus phase tracking and the wake synchroniser
  reg  [7:0]  file_reg [0:FILE_WORDS-1];
  reg  [7:0]  status;
  reg  [8:0]  pc;
  reg  [8:0]  return_stack_top;
  reg         discard_next;
  reg         sleeping;
  reg         wr_pend;
  reg         rd_pend;
  reg  [7:0]  dp_addr;
  reg         wake_meta;
  reg         wake_sync;
  integer     i;

  // Decode of the instruction written to the command register
  // hwdata_i carries the word only in the data phase, so it is used with cmd_wr
  wire [3:0]  op       = hwdata_i[`OP_MSB:`OP_LSB];
  wire [7:0]  literal  = hwdata_i[`LIT_MSB:0];
  wire [4:0]  faddr    = hwdata_i[`FADDR_MSB:0];
  wire        dest     = hwdata_i[`DEST_BIT];
  wire [7:0]  fval     = file_reg[faddr];
  wire        carry    = status[`ST_CARRY];

  // Rotate results, one per direction, each shared by both destinations
  wire [8:0]  rot_left  = rotate_carry(fval, carry, 1'b1);
  wire [8:0]  rot_right = rotate_carry(fval, carry, 1'b0);

  // Subtract as f + ~w + 1 so carry reads as no borrow
  // A separate 5-bit nibble sum gives the borrow out of bit 3
  wire [8:0]  sub_full = {1'b0, fval} + {1'b0, ~acc_o} + 9'h001;
  wire [4:0]  sub_nib  = {1'b0, fval[3:0]} + {1'b0, ~acc_o[3:0]} + 5'h01;
  wire [7:0]  sub_res  = sub_full[7:0];

  // Bus decode
  // A transfer is taken only while hready is high, as the protocol asks
  wire        take     = hsel_i & hready_i & htrans_i[1];
  wire        in_file  = dp_addr[7];
  wire        cmd_wr   = wr_pend & (dp_addr == `ADDR_COMMAND);

  // ****************************************************************
  // Wake synchroniser
  // ****************************************************************
  // Two stages; only the second is looked at by the core
  // The first stage may go metastable, so nothing else reads it
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else if (clk_en_i) begin
      wake_meta <= wake_i;
      wake_sync <= wake_meta;
    end
  end

  // ****************************************************************
  // AHB-Lite slave phases
  // ****************************************************************
  // Reads take one wait state so a write just ahead of them is seen
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      dp_addr     <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h00000000;
    end else if (clk_en_i) begin
      hresp_o <= 1'b0;
      if (rd_pend) begin
        // Wait state: no address phase can be taken while hready is low
        // hrdata then holds until the next read completes
        rd_pend     <= 1'b0;
        hreadyout_o <= 1'b1;
        if (in_file) begin
          hrdata_o <= {24'h000000, file_reg[file_index(dp_addr)]};
        end else begin
          case (dp_addr)
            `ADDR_ACC:        hrdata_o <= {24'h000000, acc_o};
            `ADDR_OPTION:     hrdata_o <= {24'h000000, option_o};
            `ADDR_STATUS:     hrdata_o <= {24'h000000, status};
            `ADDR_PC:         hrdata_o <= {23'h000000, pc};
            `ADDR_RETURN_TOP: hrdata_o <= {23'h000000, return_stack_top};
            `ADDR_CORE_STATE: hrdata_o <= {30'h00000000, sleeping, discard_next};
            default:          hrdata_o <= 32'h00000000;
          endcase
        end
      end else begin
        wr_pend <= take & hwrite_i;
        rd_pend <= take & ~hwrite_i;
        if (take) begin
          dp_addr     <= haddr_i;
          hreadyout_o <= hwrite_i;
        end
      end
    end
  end

  // ****************************************************************
  // Execute and register writes
  // ****************************************************************
  // Instructions are written to the command word; other addresses
  // let software load or inspect the core state directly
  // Execute has priority over plain writes; both cannot fall in one cycle
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_o              <= `ACC_RESET;
      option_o           <= `OPTION_RESET;
      status             <= `STATUS_RESET;
      pc                 <= `PC_RESET;
      return_stack_top   <= `PC_RESET;
      discard_next       <= 1'b0;
      sleeping           <= 1'b0;
      osc_stop_o         <= 1'b0;
      watchdog_counter_o <= `WDT_CLEARED;
      watchdog_clear_o   <= 1'b0;
      // File registers clear too, so a read never returns unknowns
      for (i = 0; i < FILE_WORDS; i = i + 1) begin
        file_reg[i] <= 8'h00;
      end
    end else if (clk_en_i) begin
      watchdog_clear_o <= 1'b0;
      // Watchdog image counts while awake and stands still in the halt,
      // since the oscillator that would advance it is stopped
      if (!sleeping) begin
        watchdog_counter_o <= watchdog_counter_o + `WDT_STEP;
      end
      // Wake leaves the halt; the instruction after sleep runs next
      if (sleeping && wake_sync) begin
        sleeping   <= 1'b0;
        osc_stop_o <= 1'b0;
      end
      if (cmd_wr) begin
        if (sleeping) begin
          // Halted: instructions are ignored until wake or reset
          pc <= pc;
        end else if (discard_next) begin
          // Second cycle of a return: the prefetched word is dropped
          discard_next <= 1'b0;
        end else begin
          // Every executed word advances pc; a return overrides it below
          pc <= pc + 9'h001;
          case (op)
            `OP_IDLE: begin
              pc <= pc + 9'h001;
            end
            `OP_LOAD_LITERAL: begin
              acc_o <= literal;
            end
            `OP_OPTION_LOAD: begin
              option_o <= acc_o;
            end
            `OP_RETURN_LITERAL: begin
              acc_o        <= literal;
              pc           <= return_stack_top;
              discard_next <= 1'b1;
            end
            `OP_SLEEP: begin
              // Pin wake flag in status bit 7 is left alone on purpose
              watchdog_counter_o      <= `WDT_CLEARED;
              watchdog_clear_o        <= 1'b1;
              status[`ST_TIMEOUT_N]   <= 1'b1;
              status[`ST_POWERDOWN_N] <= 1'b0;
              sleeping                <= 1'b1;
              osc_stop_o              <= 1'b1;
            end
            `OP_ROTATE_LEFT: begin
              status[`ST_CARRY] <= rot_left[8];
              if (dest) begin
                file_reg[faddr] <= rot_left[7:0];
              end else begin
                acc_o <= rot_left[7:0];
              end
            end
            `OP_ROTATE_RIGHT: begin
              status[`ST_CARRY] <= rot_right[8];
              if (dest) begin
                file_reg[faddr] <= rot_right[7:0];
              end else begin
                acc_o <= rot_right[7:0];
              end
            end
            `OP_SUBTRACT: begin
              status[`ST_CARRY]       <= sub_full[8];
              status[`ST_DIGIT_CARRY] <= sub_nib[4];
              status[`ST_ZERO]        <= (sub_res == 8'h00);
              if (dest) begin
                file_reg[faddr] <= sub_res;
              end else begin
                acc_o <= sub_res;
              end
            end
            default: begin
              // Codes outside the subset behave as an idle cycle
              pc <= pc + 9'h001;
            end
          endcase
        end
      end else if (wr_pend) begin
        // Plain register writes; status may be rewritten in full by software
        if (in_file) begin
          file_reg[file_index(dp_addr)] <= hwdata_i[7:0];
        end else begin
          case (dp_addr)
            `ADDR_ACC:        acc_o            <= hwdata_i[7:0];
            `ADDR_OPTION:     option_o         <= hwdata_i[7:0];
            `ADDR_STATUS:     status           <= hwdata_i[7:0];
            `ADDR_PC:         pc               <= hwdata_i[8:0];
            `ADDR_RETURN_TOP: return_stack_top <= hwdata_i[8:0];
            default:          pc               <= pc;
          endcase
        end
      end
    end
  end

endmodule

// ===== dv/exec_subset_chk.sv
/*
  Checker for the execute subset core, watching only its top-level ports.
  Assumes one clock, the asynchronous active-low reset, and hready tied back to hreadyout.
*/
`timescale 1ns/10ps
`include "exec_subset_defines.vh"

module exec_subset_chk (
  // Clock and reset
  input wire       ref_clk_i,
  input wire       reset_n_i,
  // Bus side
  input wire       hsel_i,
  input wire [7:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire       hwrite_i,
  input wire [31:0] hwdata_i,
  input wire       hready_i,
  input wire       hreadyout_o,
  // Core links
  input wire       wake_i,
  input wire [7:0] acc_o,
  input wire [7:0] option_o,
  input wire [7:0] watchdog_counter_o,
  input wire       watchdog_clear_o,
  input wire       osc_stop_o
);
  // ****************************************************************
  // Command tracking
  // ****************************************************************
  reg        cmd_d;
  reg        disc;
  wire       take = cmd_d & hready_i;
  wire       exec = take & ~disc & ~osc_stop_o;
  wire [3:0] op   = hwdata_i[11:8];

  // Tracks the pending discard, since the slot after a return is lost
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_d <= 1'b0;
      disc  <= 1'b0;
    end else begin
      if (hready_i)
        cmd_d <= hsel_i & htrans_i[1] & hwrite_i & (haddr_i == `ADDR_COMMAND);
      if (exec && op == `OP_RETURN_LITERAL)
        disc <= 1'b1;
      else if (take && !osc_stop_o)
        disc <= 1'b0;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence read_take;
    hready_i && hsel_i && htrans_i[1] && !hwrite_i;
  endsequence
  sequence one_wait;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  sequence wake_quiet;
    !wake_i [*4];
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  literal_load_a: assert property (exec && op == `OP_LOAD_LITERAL |=> acc_o == $past(hwdata_i[7:0]))
    else $error("literal load did not reach the accumulator");
  option_load_a: assert property (exec && op == `OP_OPTION_LOAD |=> option_o == $past(acc_o))
    else $error("option register does not hold the accumulator");
  return_acc_a: assert property (exec && op == `OP_RETURN_LITERAL |=> acc_o == $past(hwdata_i[7:0]))
    else $error("return did not load the literal");
  discard_slot_a: assert property (take && disc && !osc_stop_o |=> $stable(acc_o) && $stable(option_o))
    else $error("discarded slot changed state");
  sleep_clear_a: assert property (exec && op == `OP_SLEEP |=>
    watchdog_clear_o && watchdog_counter_o == `WDT_CLEARED ##1 !watchdog_clear_o)
    else $error("sleep did not clear the watchdog with one pulse");
  sleep_halt_a: assert property (exec && op == `OP_SLEEP |=> osc_stop_o)
    else $error("sleep did not stop the oscillator");
  halt_hold_a: assert property (wake_quiet ##0 osc_stop_o |=> osc_stop_o)
    else $error("halt ended without wake");
  halt_count_a: assert property ($past(osc_stop_o) |-> $stable(watchdog_counter_o))
    else $error("watchdog image moved during halt");
  wake_release_a: assert property ($rose(wake_i) && osc_stop_o |-> ##[1:5] !osc_stop_o)
    else $error("wake did not restart the core");
  file_dest_a: assert property (exec && op >= `OP_ROTATE_LEFT && op <= `OP_SUBTRACT && hwdata_i[`DEST_BIT]
    |=> $stable(acc_o))
    else $error("file destination touched the accumulator");
  read_wait_a: assert property (read_take |=> one_wait)
    else $error("read answer not after one wait");
endmodule

bind exec_subset_core exec_subset_chk chk (.ref_clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hwdata_i, .hready_i, .hreadyout_o, .wake_i, .acc_o, .option_o, .watchdog_counter_o, .watchdog_clear_o,
  .osc_stop_o);

// ===== dv/mcu_instruction_execute_subset_tb.sv
/*
  Self-checking bench for the execute subset core, driving its AHB-Lite port.
  Assumes the core answers writes with no wait and reads with one wait.
*/
`timescale 1ns/10ps
`include "exec_subset_defines.vh"

module mcu_instruction_execute_subset_tb;
  typedef struct packed {logic [3:0] op; logic d; logic [7:0] f; logic [7:0] a; logic c;} case_t;
  logic        clk, rst_n, hsel, hwrite, hready, wake, wclr, ostop, hresp;
  logic [7:0]  haddr, acc, opt, wdc, r, st0;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rdat;
  logic        c2, dc, z;
  int          compares, miscompares, cycles, n;
  case_t       tbl [6] = '{'{4'h5, 1'b0, 8'h81, 8'h00, 1'b0}, '{4'h5, 1'b1, 8'h40, 8'h00, 1'b1},
                           '{4'h6, 1'b0, 8'h01, 8'h00, 1'b1}, '{4'h6, 1'b1, 8'h80, 8'h00, 1'b0},
                           '{4'h7, 1'b0, 8'h30, 8'h30, 1'b0}, '{4'h7, 1'b1, 8'h10, 8'h21, 1'b1}};
  logic [7:0]  lits [3] = '{8'h00, 8'hA5, 8'hFF};

  exec_subset_core dut (.ref_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .wake_i(wake), .acc_o(acc), .option_o(opt), .watchdog_counter_o(wdc),
    .watchdog_clear_o(wclr), .osc_stop_o(ostop));

  // ****************************************************************
  // Clock, timeout and bus tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer; the idle edge at entry keeps drivers off the previous edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] lo);
    wr(`ADDR_COMMAND, {20'h0, op, lo});
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 8'h00; htrans = 2'b00; hwdata = 32'h0; wake = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADDR_ACC, 32'h0, "acc");
    rd(`ADDR_OPTION, 32'hFF, "option");
    rd(`ADDR_STATUS, 32'h18, "status");
    chk("hresp", 32'h0, {31'h0, hresp});
    wr(8'h40, 32'hA5);
    rd(8'h40, 32'h0, "unmapped");
    $display("test reset done");
    wr(`ADDR_STATUS, 32'h1F);
    foreach (lits[i]) begin
      cmd(`OP_LOAD_LITERAL, lits[i]);
      rd(`ADDR_ACC, {24'h0, lits[i]}, "acc");
      rd(`ADDR_STATUS, 32'h1F, "status");
    end
    cmd(`OP_LOAD_LITERAL, 8'h5A);
    cmd(`OP_OPTION_LOAD, 8'h00);
    // Outputs are looked at one edge after the write that updates them
    @(posedge clk);
    chk("option port", 32'h5A, {24'h0, opt});
    rd(`ADDR_STATUS, 32'h1F, "status");
    $display("test literal and option done");
    wr(`ADDR_RETURN_TOP, 32'h123);
    cmd(`OP_RETURN_LITERAL, 8'h3C);
    rd(`ADDR_ACC, 32'h3C, "acc");
    rd(`ADDR_PC, 32'h123, "pc");
    rd(`ADDR_STATUS, 32'h1F, "status");
    cmd(`OP_LOAD_LITERAL, 8'h55);
    rd(`ADDR_ACC, 32'h3C, "acc");
    rd(`ADDR_PC, 32'h123, "pc");
    cmd(`OP_LOAD_LITERAL, 8'h55);
    rd(`ADDR_ACC, 32'h55, "acc");
    $display("test return done");
    // Rotates and subtracts to both destinations, flags worked out here
    foreach (tbl[i]) begin
      st0 = 8'h18 | {7'h0, tbl[i].c};
      wr(`ADDR_STATUS, {24'h0, st0});
      wr(`ADDR_ACC, {24'h0, tbl[i].a});
      wr(8'h84, {24'h0, tbl[i].f});
      cmd(tbl[i].op, {2'b00, tbl[i].d, 5'd1});
      case (tbl[i].op)
        4'h5: {c2, r} = {tbl[i].f, tbl[i].c};
        4'h6: {r, c2} = {tbl[i].c, tbl[i].f};
        default: begin
          r = tbl[i].f - tbl[i].a;
          c2 = tbl[i].f >= tbl[i].a;
        end
      endcase
      dc = tbl[i].f[3:0] >= tbl[i].a[3:0];
      z = r == 8'h00;
      rd(`ADDR_ACC, {24'h0, tbl[i].d ? tbl[i].a : r}, "acc");
      rd(8'h84, {24'h0, tbl[i].d ? r : tbl[i].f}, "file");
      rd(`ADDR_STATUS, {24'h0, tbl[i].op == 4'h7 ? {st0[7:3], z, dc, c2} : {st0[7:1], c2}}, "status");
    end
    $display("test rotate and subtract done");
    wr(`ADDR_STATUS, 32'h98);
    cmd(`OP_SLEEP, 8'h00);
    @(posedge clk);
    chk("osc stop", 32'h1, {31'h0, ostop});
    chk("watchdog", 32'h0, {24'h0, wdc});
    chk("watchdog clear", 32'h1, {31'h0, wclr});
    rd(`ADDR_STATUS, 32'h90, "status");
    cmd(`OP_LOAD_LITERAL, 8'h77);
    rd(`ADDR_ACC, {24'h0, tbl[5].a}, "acc");
    chk("watchdog halt", 32'h0, {24'h0, wdc});
    wake <= 1'b1;
    for (n = 0; n < 10 && ostop !== 1'b0; n++)
      @(posedge clk);
    chk("osc run", 32'h0, {31'h0, ostop});
    wake <= 1'b0;
    cmd(`OP_LOAD_LITERAL, 8'h77);
    rd(`ADDR_ACC, 32'h77, "acc");
    $display("test sleep done");
    end_of_test();
  end
endmodule
